// ===== hdl/bss_top.sv
`timescale 1ns/1ns
`include "bss_params.svh"
module bss_top (
  // Clock and reset
  input  wire logic              clock,
  input  wire logic              resetn,
  // Boot sources
  input  wire logic [3:0]        boot_source_field,
  input  wire logic              boot_strap_pin3,
  input  wire logic              boot_strap_pin2,
  input  wire logic              boot_strap_pin1,
  input  wire logic              boot_strap_pin0,
  // Result
  output bss_pkg::bss_boot_t     boot,
  output logic                   boot_valid
);

  // Synchroniser stages for the pins and the fuse field
  logic [3:0]          strap_meta;
  logic [3:0]          strap_sync;
  logic [3:0]          field_meta;
  logic [3:0]          field_sync;
  // Capture sequencer
  bss_pkg::bss_state_t state;
  bss_pkg::bss_state_t next_state;
  logic [1:0]          wait_cnt;
  logic [1:0]          next_wait_cnt;
  // Decoded result and its next value
  bss_pkg::bss_boot_t  dec;
  bss_pkg::bss_boot_t  next_boot;
  // Named decode wires
  wire [3:0]           strap_word;
  wire                 in_fill;
  wire                 in_hold;
  wire                 fill_done;

  // Gather the four straps, pin3 is the msb
  assign strap_word = {boot_strap_pin3, boot_strap_pin2,
                       boot_strap_pin1, boot_strap_pin0};

  // Straps are board pins, asynchronous to clock: two flops.
  // No reset here, so the chain keeps filling while reset is low.
  always_ff @(posedge clock) begin
    strap_meta <= strap_word;
    strap_sync <= strap_meta;
  end

  // Fuse field sits in another power domain, treated the same way.
  // Both words are static after power-up, so no gray code; a pin
  // that moves inside the fill window can tear the captured word.
  always_ff @(posedge clock) begin
    field_meta <= boot_source_field;
    field_sync <= field_meta;
  end

  // Table lookup on the settled words
  bss_decode u_dec (
    .field (field_sync),
    .strap (strap_sync),
    .boot  (dec)
  );

  // Sequencer decode
  assign in_fill   = (state == bss_pkg::BSS_ST_FILL);
  assign in_hold   = (state == bss_pkg::BSS_ST_HOLD);
  assign fill_done = in_fill && (wait_cnt == `BSS_SYNC_CYCLES);

  // Fill for a fixed count, then hold until the next reset.
  // The count covers the synchroniser depth, nothing more.
  always_comb begin
    next_state    = state;
    next_wait_cnt = wait_cnt;
    case (state)
      bss_pkg::BSS_ST_FILL: begin
        if (fill_done) begin
          next_state = bss_pkg::BSS_ST_HOLD;
        end else begin
          next_wait_cnt = wait_cnt + 2'h1;
        end
      end
      bss_pkg::BSS_ST_HOLD: begin
        next_state = bss_pkg::BSS_ST_HOLD;
      end
      default: begin
        next_state    = bss_pkg::BSS_ST_FILL;
        next_wait_cnt = 2'h0;
      end
    endcase
  end

  // Result loads once, on the edge that leaves the fill state
  assign next_boot = fill_done ? dec : boot;

  // Sequencer registers; a stray code falls back to filling
  always_ff @(posedge clock) begin
    if (!resetn) begin
      state    <= bss_pkg::BSS_ST_FILL;
      wait_cnt <= 2'h0;
    end else begin
      state    <= next_state;
      wait_cnt <= next_wait_cnt;
    end
  end

  // Cleared in reset so a loader sees no mode before capture.
  // Pin changes after capture are ignored until the next reset.
  always_ff @(posedge clock) begin
    if (!resetn) begin
      boot <= '0;
    end else begin
      boot <= next_boot;
    end
  end

  // Valid is the hold state itself, so it comes from a flop
  assign boot_valid = in_hold;

  // Steps of one capture: release, fill, then valid rises
  sequence s_released;
    $rose(resetn);
  endsequence

  sequence s_filling;
    !boot_valid [*3];
  endsequence

  sequence s_captured;
    $rose(boot_valid);
  endsequence

  // Capture timing: three low samples after release, then high
  a_valid_time: assert property (
    @(posedge clock) s_released |-> s_filling ##1 boot_valid)
    else $error("capture timing wrong");

  // Held value never changes once valid
  a_boot_hold: assert property (
    @(posedge clock) disable iff (!resetn)
    $past(boot_valid) |-> $stable(boot))
    else $error("boot mode changed after capture");

  // Reset clears the result and the valid flag
  a_reset_clear: assert property (
    @(posedge clock) !resetn |=>
    boot.mode == bss_pkg::BSS_NONE && !boot_valid)
    else $error("result not cleared by reset");

  // Field code 1000 selects SPI flash on sync port 0
  a_field_wins: assert property (
    @(posedge clock) disable iff (!resetn)
    s_captured ##0 (field_sync == `BSS_FLD_SSP) |->
    boot.mode == bss_pkg::BSS_SSP && boot.from_field)
    else $error("field 1000 did not pick sync port flash");

  // Field code 1001 selects programming over async port 3
  a_field_uart3: assert property (
    @(posedge clock) disable iff (!resetn)
    s_captured ##0 (field_sync == `BSS_FLD_UART3) |->
    boot.mode == bss_pkg::BSS_UART3 && boot.from_field)
    else $error("field 1001 did not pick async port 3");

  // Field code 0110 selects the first usb port
  a_usb_field: assert property (
    @(posedge clock) disable iff (!resetn)
    s_captured ##0 (field_sync == `BSS_FLD_USB_A) |->
    boot.mode == bss_pkg::BSS_USB_A && boot.from_field)
    else $error("usb field code not honoured");

  // Any nonzero field overrides the straps, listed or not
  a_field_override: assert property (
    @(posedge clock) disable iff (!resetn)
    s_captured ##0 (field_sync != 4'h0) |-> boot.from_field)
    else $error("nonzero field did not override straps");

  // Zero field hands the choice to the straps
  a_strap_used: assert property (
    @(posedge clock) disable iff (!resetn)
    s_captured ##0 (field_sync == 4'h0) |->
    !boot.from_field && boot.mode != bss_pkg::BSS_NONE)
    else $error("zero field did not defer to straps");

  // Unlisted strap codes report a bad mode, never a real one
  a_strap_bad: assert property (
    @(posedge clock) disable iff (!resetn)
    s_captured ##0 (field_sync == 4'h0 && strap_sync > `BSS_STR_UART3) |->
    boot.mode == bss_pkg::BSS_BAD)
    else $error("unlisted strap code not flagged bad");

  // Quad flash needs its own pin function on the shared pins
  a_qspi_pinfn: assert property (
    @(posedge clock) disable iff (!resetn)
    boot_valid && boot.mode == bss_pkg::BSS_QSPI |->
    boot.flash_pinfn == `BSS_PINFN_QSPI)
    else $error("quad flash pin function wrong");

  // Sync port flash gets the serial port pin function
  a_ssp_pinfn: assert property (
    @(posedge clock) disable iff (!resetn)
    boot_valid && boot.mode == bss_pkg::BSS_SSP |->
    boot.flash_pinfn == `BSS_PINFN_SSP)
    else $error("sync port flash pin function wrong");

  // The two flash kinds never share a pin function
  a_pinfn_diff: assert property (
    @(posedge clock) disable iff (!resetn)
    boot_valid && boot.mode == bss_pkg::BSS_QSPI |->
    boot.flash_pinfn != `BSS_PINFN_SSP)
    else $error("quad flash pin function equals sync port");

  // Static memory width follows the selected mode
  a_mem8_width: assert property (
    @(posedge clock) disable iff (!resetn)
    boot_valid && boot.mode == bss_pkg::BSS_MEM8 |-> boot.mem_width == 2'h0)
    else $error("8-bit memory width wrong");

  // 16-bit bus reports width code 1
  a_mem16_width: assert property (
    @(posedge clock) disable iff (!resetn)
    boot_valid && boot.mode == bss_pkg::BSS_MEM16 |-> boot.mem_width == 2'h1)
    else $error("16-bit memory width wrong");

  // 32-bit bus reports width code 2
  a_mem32_width: assert property (
    @(posedge clock) disable iff (!resetn)
    boot_valid && boot.mode == bss_pkg::BSS_MEM32 |-> boot.mem_width == 2'h2)
    else $error("32-bit memory width wrong");

  // Sequencer never leaves its two legal codes
  a_state_onehot: assert property (
    @(posedge clock) disable iff (!resetn)
    $onehot(state))
    else $error("sequencer state not one-hot");

endmodule

// ===== hdl/bss_params.svh
`ifndef BSS_PARAMS_SVH
`define BSS_PARAMS_SVH

// Boot source field codes
`define BSS_FLD_USB_A     4'h6
`define BSS_FLD_USB_B     4'h7
`define BSS_FLD_SSP       4'h8
`define BSS_FLD_UART3     4'h9
// Strap codes, pin3 is the msb
`define BSS_STR_UART0     4'h0
`define BSS_STR_QSPI      4'h1
`define BSS_STR_MEM8      4'h2
`define BSS_STR_MEM16     4'h3
`define BSS_STR_MEM32     4'h4
`define BSS_STR_USB_A     4'h5
`define BSS_STR_USB_B     4'h6
`define BSS_STR_SSP       4'h7
`define BSS_STR_UART3     4'h8
// Pin function codes for the shared flash port pins
`define BSS_PINFN_GPIO    3'h0
`define BSS_PINFN_SSP     3'h2
`define BSS_PINFN_QSPI    3'h3
// Cycles after reset release before straps are caught
`define BSS_SYNC_CYCLES   2'h2

`endif

// ===== hdl/bss_pkg.sv
package bss_pkg;

  // Boot modes, one-hot except BSS_NONE, which is all zero
  typedef enum logic [9:0] {
    BSS_NONE  = 10'h000,
    BSS_UART0 = 10'h001,
    BSS_QSPI  = 10'h002,
    BSS_MEM8  = 10'h004,
    BSS_MEM16 = 10'h008,
    BSS_MEM32 = 10'h010,
    BSS_USB_A = 10'h020,
    BSS_USB_B = 10'h040,
    BSS_SSP   = 10'h080,
    BSS_UART3 = 10'h100,
    BSS_BAD   = 10'h200
  } bss_mode_t;

  // Capture sequencer states, one-hot
  typedef enum logic [1:0] {
    BSS_ST_FILL = 2'h1,
    BSS_ST_HOLD = 2'h2
  } bss_state_t;

  // Decoded boot result
  typedef struct packed {
    bss_mode_t  mode;
    logic [1:0] mem_width;  // 0:8 1:16 2:32 bits
    logic [2:0] flash_pinfn;
    logic       from_field;
  } bss_boot_t;

endpackage

// ===== hdl/bss_decode.sv
`timescale 1ns/1ns
`include "bss_params.svh"
module bss_decode (
  // Sources
  input  wire logic [3:0]         field,
  input  wire logic [3:0]         strap,
  // Result
  output bss_pkg::bss_boot_t      boot
);

  wire use_field = (field != 4'h0);
  bss_pkg::bss_mode_t fmode;
  bss_pkg::bss_mode_t smode;
  bss_pkg::bss_mode_t mode;

  // Field table
  always_comb begin
    case (field)
      `BSS_FLD_USB_A: fmode = bss_pkg::BSS_USB_A;
      `BSS_FLD_USB_B: fmode = bss_pkg::BSS_USB_B;
      `BSS_FLD_SSP:   fmode = bss_pkg::BSS_SSP;
      `BSS_FLD_UART3: fmode = bss_pkg::BSS_UART3;
      default:        fmode = bss_pkg::BSS_BAD;
    endcase
  end

  // Strap table
  always_comb begin
    case (strap)
      `BSS_STR_UART0: smode = bss_pkg::BSS_UART0;
      `BSS_STR_QSPI:  smode = bss_pkg::BSS_QSPI;
      `BSS_STR_MEM8:  smode = bss_pkg::BSS_MEM8;
      `BSS_STR_MEM16: smode = bss_pkg::BSS_MEM16;
      `BSS_STR_MEM32: smode = bss_pkg::BSS_MEM32;
      `BSS_STR_USB_A: smode = bss_pkg::BSS_USB_A;
      `BSS_STR_USB_B: smode = bss_pkg::BSS_USB_B;
      `BSS_STR_SSP:   smode = bss_pkg::BSS_SSP;
      `BSS_STR_UART3: smode = bss_pkg::BSS_UART3;
      default:        smode = bss_pkg::BSS_BAD;
    endcase
  end

  // Field wins over straps
  assign mode = use_field ? fmode : smode;
  assign boot.mode = mode;
  assign boot.from_field = use_field;
  assign boot.mem_width = (mode == bss_pkg::BSS_MEM32) ? 2'h2 :
                          (mode == bss_pkg::BSS_MEM16) ? 2'h1 : 2'h0;
  // Same pins, different function per flash kind
  assign boot.flash_pinfn =
    (mode == bss_pkg::BSS_QSPI) ? `BSS_PINFN_QSPI :
    (mode == bss_pkg::BSS_SSP)  ? `BSS_PINFN_SSP  :
    `BSS_PINFN_GPIO;

endmodule

// ===== verification/bss_strap_model.sv
`timescale 1ns/1ns
module bss_strap_model (
  // Wanted strap code, pin3 first
  input  wire logic [3:0] code,
  // Board strap pins
  output logic            pin3,
  output logic            pin2,
  output logic            pin1,
  output logic            pin0
);
  // Resistor straps are static, so no release state
  assign {pin3, pin2, pin1, pin0} = code;
endmodule

// ===== verification/test_boot_source_select.sv
`timescale 1ns/1ns
module test_boot_source_select;
  logic               clock;
  logic               resetn;
  logic [3:0]         field;
  logic [3:0]         code;
  logic               p3, p2, p1, p0;
  logic               boot_valid;
  bss_pkg::bss_boot_t boot;
  int                 miscompares = 0;
  int                 samples_checked = 0;
  // Board straps and the unit
  bss_strap_model strap (.code(code), .pin3(p3), .pin2(p2), .pin1(p1),
    .pin0(p0));
  bss_top uut (.clock(clock), .resetn(resetn), .boot_source_field(field),
    .boot_strap_pin3(p3), .boot_strap_pin2(p2), .boot_strap_pin1(p1),
    .boot_strap_pin0(p0), .boot(boot), .boot_valid(boot_valid));
  // Clock, 8 ns period
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  task close_out();
    $display("checked %0d miscompares %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task chk_bit(string what, logic e, logic g);
    samples_checked++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %s exp %b got %b", what, e, g);
    end
  endtask
  // Whole decoded word; width reads zero outside memory boot
  task chk_boot(string what, logic [9:0] m, logic [1:0] w, logic [2:0] f,
                logic ff);
    bss_pkg::bss_boot_t e;
    e = {m, w, f, ff};
    samples_checked++;
    if (boot !== e) begin
      miscompares++;
      $display("[ERR] %s exp %h got %h", what, e, boot);
    end
  endtask
  // Reset, apply sources, release and time the capture
  task boot_run(logic [3:0] f, logic [3:0] c);
    resetn = 1'b0;
    field = f;
    code = c;
    repeat (2) @(negedge clock);
    chk_bit("reset valid", 1'b0, boot_valid);
    chk_boot("reset boot", 10'h000, 2'h0, 3'h0, 1'b0);
    resetn = 1'b1;
    // Valid rises on the third edge after release
    repeat (2) @(negedge clock);
    chk_bit("valid early", 1'b0, boot_valid);
    @(negedge clock);
    chk_bit("valid on time", 1'b1, boot_valid);
  endtask
  task test_straps();
    logic [9:0] m;
    logic [1:0] w;
    logic [2:0] f;
    for (int c = 0; c < 9; c++) begin
      m = 10'h001 << c;
      w = (c >= 2 && c <= 4) ? 2'(c - 2) : 2'h0;
      f = (c == 1) ? 3'h3 : (c == 7) ? 3'h2 : 3'h0;
      boot_run(4'h0, 4'(c));
      chk_boot("strap", m, w, f, 1'b0);
    end
    $display("test_straps done");
  endtask
  task test_field();
    boot_run(4'h8, 4'h1);
    chk_boot("field ssp", 10'h080, 2'h0, 3'h2, 1'b1);
    boot_run(4'h9, 4'h0);
    chk_boot("field uart3", 10'h100, 2'h0, 3'h0, 1'b1);
    boot_run(4'h6, 4'h7);
    chk_boot("field usb a", 10'h020, 2'h0, 3'h0, 1'b1);
    boot_run(4'h7, 4'h2);
    chk_boot("field usb b", 10'h040, 2'h0, 3'h0, 1'b1);
    $display("test_field done");
  endtask
  task test_hold();
    boot_run(4'h0, 4'h2);
    // Move both sources after capture; neither may show
    code = 4'h4;
    field = 4'h9;
    repeat (6) @(negedge clock);
    chk_boot("held mode", 10'h004, 2'h0, 3'h0, 1'b0);
    chk_bit("held valid", 1'b1, boot_valid);
    $display("test_hold done");
  endtask
  // Codes outside both tables give the bad mode
  task test_unlisted();
    boot_run(4'h0, 4'hF);
    chk_boot("strap bad", 10'h200, 2'h0, 3'h0, 1'b0);
    boot_run(4'h1, 4'h7);
    chk_boot("field bad", 10'h200, 2'h0, 3'h0, 1'b1);
    $display("test_unlisted done");
  endtask
  initial begin
    resetn = 1'b0;
    field = 4'h0;
    code = 4'h0;
    repeat (8) @(negedge clock);
    test_straps();
    test_field();
    test_hold();
    test_unlisted();
    close_out();
  end
endmodule
